/* hdl/gpio_function_pkg.sv */
// Constants and carrier types for the four-pin general-purpose function multiplexer.
// Assumes a single register clock and an AXI4-Lite master with 12-bit byte addresses.
package gpio_function_pkg;

  // ----------------------------------------------------------------------------
  // Register indices; the byte address is four times the index.
  // ----------------------------------------------------------------------------
  localparam logic [9:0] IDX_PIN_DIRECTION = 10'h06e;
  localparam logic [9:0] IDX_INPUT_SELECT_BIT2 = 10'h06f;
  localparam logic [9:0] IDX_INPUT_SELECT_BIT1 = 10'h070;
  localparam logic [9:0] IDX_INPUT_SELECT_BIT0 = 10'h071;
  localparam logic [9:0] IDX_OUTPUT_SELECT_BIT2 = 10'h072;
  localparam logic [9:0] IDX_OUTPUT_SELECT_BIT1 = 10'h073;
  localparam logic [9:0] IDX_OUTPUT_SELECT_BIT0 = 10'h074;
  localparam logic [9:0] IDX_RESERVED_SLOT = 10'h075;
  localparam logic [9:0] IDX_OUTPUT_VALUE = 10'h076;
  localparam logic [9:0] IDX_INPUT_VALUE = 10'h219;
  localparam int ADDR_WIDTH = 12;
  localparam int PIN_COUNT = 4;
  localparam int CLOCK_OUT_COUNT = 8;

  // ----------------------------------------------------------------------------
  // Reset values and function codes.
  // ----------------------------------------------------------------------------
  localparam logic [3:0] RESET_DIRECTION = 4'h0;
  localparam logic [3:0] RESET_SELECT = 4'h0;
  localparam logic [3:0] RESET_OUTPUT_VALUE = 4'h0;
  localparam logic [2:0] CODE_PLAIN = 3'h0;
  localparam logic [2:0] CODE_FIRST = 3'h1;
  localparam logic [2:0] CODE_SECOND = 3'h2;
  localparam logic [2:0] CODE_REF_SELECT = 3'h5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Status flags produced by the loop and reference monitor logic.
  typedef struct packed {
    logic [1:0] loss_of_lock;
    logic [1:0] holdover;
    logic [1:0] loss_of_signal;
  } loop_status_t;

  // Pin-driven controls handed to clock outputs and loops.
  typedef struct packed {
    logic [7:0] clock_enable_owned;
    logic [7:0] clock_enable_level;
    logic [1:0] ref_select_owned;
    logic [1:0] ref_select_level;
  } pin_control_t;

endpackage

/* hdl/gpio_function_mux.sv */
// Four general-purpose pins with per-pin input and output functions, behind an AXI4-Lite slave.
// Assumes status flags arrive from logic on aclk and pin levels arrive asynchronously.
`timescale 1ns/100ps
module gpio_function_mux
  import gpio_function_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] gpio_in,
  output logic [3:0] gpio_out,
  output logic [3:0] gpio_oe,
  input wire loop_status_t loop_status,
  output pin_control_t pin_control
);

  // ----------------------------------------------------------------------------
  // Register state.
  // ----------------------------------------------------------------------------
  logic [3:0] pin_direction;
  logic [3:0] input_select_bit2;
  logic [3:0] input_select_bit1;
  logic [3:0] input_select_bit0;
  logic [3:0] output_select_bit2;
  logic [3:0] output_select_bit1;
  logic [3:0] output_select_bit0;
  logic [3:0] output_value;
  logic [3:0] input_value;
  logic [3:0] gpio_meta;
  logic [3:0] gpio_sync;
  logic aw_held;
  logic w_held;
  logic [9:0] aw_index;
  logic [31:0] w_data;
  logic w_lane0;
  logic do_write;
  logic write_hit;
  logic [31:0] next_rdata;
  logic read_hit;
  logic [3:0] next_gpio_out;
  wire logic [3:0] plain_input;
  wire pin_control_t next_pin_control;
  logic [2:0] in_code [PIN_COUNT];
  logic [2:0] out_code [PIN_COUNT];

  // ----------------------------------------------------------------------------
  // Write channel: address and data are taken in either order and joined.
  // ----------------------------------------------------------------------------

  // The write fires once both halves are held and no response is still waiting.
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  // Latch the write address; awready falls as soon as one is held.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_index <= 10'h000;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_index <= s_axi_awaddr[ADDR_WIDTH-1:2];
      s_axi_awready <= 1'b0;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end else if (!aw_held) begin
      s_axi_awready <= 1'b1;
    end
  end

  // Latch the write data and its low byte lane strobe.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_lane0 <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_lane0 <= s_axi_wstrb[0];
      s_axi_wready <= 1'b0;
    end else if (do_write) begin
      w_held <= 1'b0;
    end else if (!w_held) begin
      s_axi_wready <= 1'b1;
    end
  end

  // Decode which indices accept a write; the read-only and reserved slots answer okay but store nothing.
  always_comb begin
    unique case (aw_index)
      IDX_PIN_DIRECTION, IDX_INPUT_SELECT_BIT2, IDX_INPUT_SELECT_BIT1, IDX_INPUT_SELECT_BIT0,
      IDX_OUTPUT_SELECT_BIT2, IDX_OUTPUT_SELECT_BIT1, IDX_OUTPUT_SELECT_BIT0, IDX_RESERVED_SLOT,
      IDX_OUTPUT_VALUE, IDX_INPUT_VALUE: write_hit = 1'b1;
      default: write_hit = 1'b0;
    endcase
  end

  // Write response follows the joined write one edge later.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= write_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // Control registers. Only the low four bits are stored; the rest read as zero.
  // ----------------------------------------------------------------------------

  // Direction and select fields reset to input with the plain function.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_direction <= RESET_DIRECTION;
      input_select_bit2 <= RESET_SELECT;
      input_select_bit1 <= RESET_SELECT;
      input_select_bit0 <= RESET_SELECT;
      output_select_bit2 <= RESET_SELECT;
      output_select_bit1 <= RESET_SELECT;
      output_select_bit0 <= RESET_SELECT;
      output_value <= RESET_OUTPUT_VALUE;
    end else if (do_write && w_lane0) begin
      unique case (aw_index)
        IDX_PIN_DIRECTION: pin_direction <= w_data[3:0];
        IDX_INPUT_SELECT_BIT2: input_select_bit2 <= w_data[3:0];
        IDX_INPUT_SELECT_BIT1: input_select_bit1 <= w_data[3:0];
        IDX_INPUT_SELECT_BIT0: input_select_bit0 <= w_data[3:0];
        IDX_OUTPUT_SELECT_BIT2: output_select_bit2 <= w_data[3:0];
        IDX_OUTPUT_SELECT_BIT1: output_select_bit1 <= w_data[3:0];
        IDX_OUTPUT_SELECT_BIT0: output_select_bit0 <= w_data[3:0];
        IDX_OUTPUT_VALUE: output_value <= w_data[3:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Read channel.
  // ----------------------------------------------------------------------------

  // Reserved upper bits and the reserved slot read as zero, so software gains nothing from them.
  always_comb begin
    next_rdata = 32'h0000_0000;
    read_hit = 1'b1;
    unique case (s_axi_araddr[ADDR_WIDTH-1:2])
      IDX_PIN_DIRECTION: next_rdata[3:0] = pin_direction;
      IDX_INPUT_SELECT_BIT2: next_rdata[3:0] = input_select_bit2;
      IDX_INPUT_SELECT_BIT1: next_rdata[3:0] = input_select_bit1;
      IDX_INPUT_SELECT_BIT0: next_rdata[3:0] = input_select_bit0;
      IDX_OUTPUT_SELECT_BIT2: next_rdata[3:0] = output_select_bit2;
      IDX_OUTPUT_SELECT_BIT1: next_rdata[3:0] = output_select_bit1;
      IDX_OUTPUT_SELECT_BIT0: next_rdata[3:0] = output_select_bit0;
      IDX_RESERVED_SLOT: next_rdata = 32'h0000_0000;
      IDX_OUTPUT_VALUE: next_rdata[3:0] = output_value;
      IDX_INPUT_VALUE: next_rdata[3:0] = input_value;
      default: read_hit = 1'b0;
    endcase
  end

  // One read at a time; the answer stands until rready.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= read_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------------
  // Pin input synchroniser.
  // ----------------------------------------------------------------------------

  // Pins are asynchronous to aclk, so two flops stand before any logic.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gpio_meta <= 4'h0;
      gpio_sync <= 4'h0;
    end else begin
      gpio_meta <= gpio_in;
      gpio_sync <= gpio_meta;
    end
  end

  // ----------------------------------------------------------------------------
  // Per-pin function decode.
  // ----------------------------------------------------------------------------
  for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
    assign in_code[i] = {input_select_bit2[i], input_select_bit1[i], input_select_bit0[i]};
    assign out_code[i] = {output_select_bit2[i], output_select_bit1[i], output_select_bit0[i]};

    // A pin reads as a plain input only in input mode with the plain code.
    assign plain_input[i] = !pin_direction[i] && (in_code[i] == CODE_PLAIN);

    // Output functions differ per pin; a reserved code falls back to the software bit.
    always_comb begin
      next_gpio_out[i] = output_value[i];
      if (out_code[i] == CODE_FIRST) begin
        unique case (i)
          0: next_gpio_out[i] = loop_status.loss_of_lock[0];
          1: next_gpio_out[i] = loop_status.holdover[0];
          2: next_gpio_out[i] = loop_status.loss_of_signal[0];
          default: next_gpio_out[i] = loop_status.loss_of_lock[1];
        endcase
      end else if (out_code[i] == CODE_SECOND) begin
        unique case (i)
          0: next_gpio_out[i] = loop_status.loss_of_lock[1];
          1: next_gpio_out[i] = loop_status.holdover[1];
          default: next_gpio_out[i] = loop_status.loss_of_signal[1];
        endcase
      end
    end

    // Clock outputs i and i+4 may take their enable from this pin in input mode.
    assign next_pin_control.clock_enable_owned[i] = !pin_direction[i] && (in_code[i] == CODE_FIRST);
    assign next_pin_control.clock_enable_owned[i+4] = !pin_direction[i] && (in_code[i] == CODE_SECOND);
    assign next_pin_control.clock_enable_level[i] = next_pin_control.clock_enable_owned[i] && gpio_sync[i];
    assign next_pin_control.clock_enable_level[i+4] = next_pin_control.clock_enable_owned[i+4] && gpio_sync[i];
  end

  // Only pins 2 and 3 can act as manual reference selects, for loop 0 and loop 1.
  for (genvar j = 0; j < 2; j++) begin : g_ref
    assign next_pin_control.ref_select_owned[j] = !pin_direction[j+2] && (in_code[j+2] == CODE_REF_SELECT);
    assign next_pin_control.ref_select_level[j] = next_pin_control.ref_select_owned[j] && gpio_sync[j+2];
  end

  // ----------------------------------------------------------------------------
  // Registered outputs.
  // ----------------------------------------------------------------------------

  // Pin drive: output mode enables the driver and selects the output function.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gpio_oe <= 4'h0;
      gpio_out <= 4'h0;
    end else begin
      gpio_oe <= pin_direction;
      gpio_out <= next_gpio_out & pin_direction;
    end
  end

  // Input value register and the controls handed to clock outputs and loops.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      input_value <= 4'h0;
      pin_control <= '0;
    end else begin
      input_value <= gpio_sync & plain_input;
      pin_control <= next_pin_control;
    end
  end

  // ----------------------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_reset_state_input: assert property (disable iff (1'b0)
    !$past(aresetn) |-> (gpio_oe == 4'h0) && (pin_direction == 4'h0) && (output_value == 4'h0))
    else $error("pins not inputs after reset");
  a_oe_follows_dir: assert property (
    gpio_oe == $past(pin_direction))
    else $error("output enable does not follow direction");
  a_input_value_pin: assert property (
    ($past(plain_input[0]) && $past(aresetn) && $past(aresetn, 2) && $past(aresetn, 3))
      |-> input_value[0] == $past(gpio_in[0], 3))
    else $error("plain input not mirrored after three edges");
  a_input_ignored_out: assert property (
    $past(pin_direction[1]) |-> !input_value[1])
    else $error("output pin shows in input value");
  a_pin0_lock_flag: assert property (
    (pin_direction[0] && out_code[0] == CODE_SECOND) |=> gpio_out[0] == $past(loop_status.loss_of_lock[1]))
    else $error("pin 0 does not show loop 1 loss of lock");
  a_pin3_signal_flag: assert property (
    (pin_direction[3] && out_code[3] == CODE_SECOND) |=> gpio_out[3] == $past(loop_status.loss_of_signal[1]))
    else $error("pin 3 does not show reference 1 loss of signal");
  a_reserved_out_plain: assert property (
    (pin_direction[1] && out_code[1] == 3'h7) |=> gpio_out[1] == $past(output_value[1]))
    else $error("reserved output code not plain");
  a_ref_select_loop0: assert property (
    (!pin_direction[2] && in_code[2] == CODE_REF_SELECT) |=> pin_control.ref_select_owned[0]
      && !pin_control.clock_enable_owned[2] && !pin_control.clock_enable_owned[6])
    else $error("pin 2 reference select not granted");
  a_clock4_enable: assert property (
    pin_control.clock_enable_owned[4] |-> $past(!pin_direction[0] && in_code[0] == CODE_SECOND))
    else $error("clock 4 enable without pin 0 code");
  a_write_resp_time: assert property (
    (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && (!s_axi_bvalid || s_axi_bready))
      |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_resp_time: assert property (
    (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
    else $error("read response missing");

  // Bus answers stand unchanged until the master takes them.
  a_read_hold: assert property (
    (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer dropped before rready");
  a_write_hold: assert property (
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped before bready");

  // Each output function code puts its flag, and the plain code the software bit, on the pin one edge later.
  a_plain_out_value: assert property (
    (pin_direction[0] && out_code[0] == CODE_PLAIN) |=> gpio_out[0] == $past(output_value[0]))
    else $error("pin 0 does not show the software value");
  a_pin0_lock_loop0: assert property (
    (pin_direction[0] && out_code[0] == CODE_FIRST) |=> gpio_out[0] == $past(loop_status.loss_of_lock[0]))
    else $error("pin 0 does not show loop 0 loss of lock");
  a_pin1_hold_loop0: assert property (
    (pin_direction[1] && out_code[1] == CODE_FIRST) |=> gpio_out[1] == $past(loop_status.holdover[0]))
    else $error("pin 1 does not show loop 0 holdover");
  a_pin1_hold_loop1: assert property (
    (pin_direction[1] && out_code[1] == CODE_SECOND) |=> gpio_out[1] == $past(loop_status.holdover[1]))
    else $error("pin 1 does not show loop 1 holdover");
  a_pin2_signal_ref0: assert property (
    (pin_direction[2] && out_code[2] == CODE_FIRST) |=> gpio_out[2] == $past(loop_status.loss_of_signal[0]))
    else $error("pin 2 does not show reference 0 loss of signal");
  a_pin2_signal_ref1: assert property (
    (pin_direction[2] && out_code[2] == CODE_SECOND) |=> gpio_out[2] == $past(loop_status.loss_of_signal[1]))
    else $error("pin 2 does not show reference 1 loss of signal");
  a_pin3_lock_loop1: assert property (
    (pin_direction[3] && out_code[3] == CODE_FIRST) |=> gpio_out[3] == $past(loop_status.loss_of_lock[1]))
    else $error("pin 3 does not show loop 1 loss of lock");

  // Input function codes hand the synchronised pin level to a clock output or loop.
  a_clock0_enable: assert property (
    (!pin_direction[0] && in_code[0] == CODE_FIRST)
      |=> pin_control.clock_enable_owned[0] && pin_control.clock_enable_level[0] == $past(gpio_sync[0]))
    else $error("pin 0 does not enable clock 0");
  a_clock5_enable: assert property (
    (!pin_direction[1] && in_code[1] == CODE_SECOND)
      |=> pin_control.clock_enable_owned[5] && pin_control.clock_enable_level[5] == $past(gpio_sync[1]))
    else $error("pin 1 does not enable clock 5");
  a_ref_select_loop1: assert property (
    (!pin_direction[3] && in_code[3] == CODE_REF_SELECT)
      |=> pin_control.ref_select_owned[1] && pin_control.ref_select_level[1] == $past(gpio_sync[3]))
    else $error("pin 3 reference select not granted");
  a_reserved_in_none: assert property (
    (!pin_direction[0] && in_code[0] == 3'h3)
      |=> !pin_control.clock_enable_owned[0] && !pin_control.clock_enable_owned[4])
    else $error("reserved input code gave pin 0 a function");
  a_output_no_control: assert property (
    pin_direction[2] |=> !pin_control.clock_enable_owned[2] && !pin_control.clock_enable_owned[6]
      && !pin_control.ref_select_owned[0])
    else $error("output pin 2 still controls a clock or loop");

endmodule // gpio_function_mux

/* bench/pin_board_model.sv */
// Board logic on the pin side of the four general-purpose pins.
// Assumes the device enable is high while the device drives a pin.
`timescale 1ns/100ps
module pin_board_model (
  input wire logic [3:0] board_drive,
  input wire logic [3:0] gpio_out,
  input wire logic [3:0] gpio_oe,
  output logic [3:0] gpio_in,
  output logic [3:0] pin_level
);
  // ---------------------------------------------------------------------------
  // Wire resolution
  // ---------------------------------------------------------------------------
  // The board lets go of a pin the device drives, so the two never fight.
  // Where the device is silent the board level stands on the wire.
  always_comb begin
    pin_level = (gpio_oe & gpio_out) | (~gpio_oe & board_drive);
  end

  // Every input sees the resolved wire, including the device's own receiver.
  assign gpio_in = pin_level;
endmodule // pin_board_model

/* bench/gpio_function_mux_tb_top.sv */
// Self-checking bench for the pin function multiplexer, driven over AXI4-Lite.
// Assumes the board model in pin_board_model.sv and the package constants.
`timescale 1ns/100ps
module gpio_function_mux_tb_top
  import gpio_function_pkg::*;
;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [ADDR_WIDTH-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [3:0] gpio_in, gpio_out, gpio_oe, board_drive, pin_level;
  loop_status_t status;
  pin_control_t ctrl;
  int bad_count = 0;
  int n_checks = 0;

  gpio_function_mux dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .loop_status(status), .pin_control(ctrl));
  pin_board_model board_u (.board_drive(board_drive), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .gpio_in(gpio_in), .pin_level(pin_level));

  // ---------------------------------------------------------------------------
  // Comparison and closing tasks
  // ---------------------------------------------------------------------------
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic check_resp(input logic [1:0] got, input logic [1:0] exp, input string msg);
    check_word({30'h0, got}, {30'h0, exp}, msg);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Bus master tasks
  // ---------------------------------------------------------------------------
  // Address and data are offered together and each is dropped at its own handshake edge.
  task automatic wr(input logic [9:0] idx, input logic [31:0] d, input logic [1:0] exp);
    logic aw_done, w_done;
    int t;
    aw_done = 1'b0;
    w_done = 1'b0;
    t = 0;
    awaddr <= {idx, 2'b00};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_done && w_done) && t < 50) begin
      @(posedge aclk);
      t++;
      if (!aw_done && awready === 1'b1) begin aw_done = 1'b1; awvalid <= 1'b0; end
      if (!w_done && wready === 1'b1) begin w_done = 1'b1; wvalid <= 1'b0; end
    end
    bready <= 1'b1;
    do begin @(posedge aclk); t++; end while (bvalid !== 1'b1 && t < 100);
    bready <= 1'b0;
    check_resp((bvalid === 1'b1) ? bresp : 2'bxx, exp, "write response");
  endtask

  // Read data is checked only when an okay answer is expected.
  task automatic rd(input logic [9:0] idx, input logic [31:0] exp_d, input logic [1:0] exp_r);
    int t;
    t = 0;
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    do begin @(posedge aclk); t++; end while (arready !== 1'b1 && t < 50);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do begin @(posedge aclk); t++; end while (rvalid !== 1'b1 && t < 100);
    rready <= 1'b0;
    check_resp((rvalid === 1'b1) ? rresp : 2'bxx, exp_r, "read response");
    if (exp_r === RESP_OKAY) check_word(rdata, exp_d, "read data");
  endtask

  // ---------------------------------------------------------------------------
  // Expected pin behaviour, worked out from the function code tables
  // ---------------------------------------------------------------------------
  function automatic pin_control_t exp_ctrl(input logic [2:0] c, input logic [3:0] lv);
    pin_control_t e;
    e = '0;
    if (c == CODE_FIRST) e.clock_enable_owned[3:0] = 4'hf;
    if (c == CODE_SECOND) e.clock_enable_owned[7:4] = 4'hf;
    if (c == CODE_REF_SELECT) e.ref_select_owned = 2'h3;
    e.clock_enable_level = e.clock_enable_owned & {lv, lv};
    e.ref_select_level = e.ref_select_owned & lv[3:2];
    return e;
  endfunction

  // Reserved output codes fall back to the software value, as code zero does.
  function automatic logic [3:0] exp_out(input logic [2:0] c, input loop_status_t s, input logic [3:0] ov);
    if (c == CODE_FIRST) return {s.loss_of_lock[1], s.loss_of_signal[0], s.holdover[0], s.loss_of_lock[0]};
    if (c == CODE_SECOND) return {s.loss_of_signal[1], s.loss_of_signal[1], s.holdover[1], s.loss_of_lock[1]};
    return ov;
  endfunction

  // ---------------------------------------------------------------------------
  // Clock, watchdog and test sequence
  // ---------------------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // The sequence needs about four hundred cycles; twenty thousand means a hang.
  initial begin
    #(8 * 20000);
    bad_count++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    tally_and_finish;
  end

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = '0;
    araddr = '0;
    wdata = 32'h0;
    board_drive = 4'hb;
    status = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int r = 0; r < 9; r++) rd(IDX_PIN_DIRECTION + 10'(r), 32'h0, RESP_OKAY);
    check_word({28'h0, gpio_oe}, 32'h0, "oe after reset");
    check_word({12'h0, ctrl}, 32'h0, "control after reset");
    rd(10'h001, 32'h0, RESP_SLVERR);
    wr(10'h001, 32'h0, RESP_SLVERR);
    wr(IDX_RESERVED_SLOT, 32'h0, RESP_OKAY);
    rd(IDX_INPUT_VALUE, 32'hb, RESP_OKAY);
    $display("test reset and map done");
    wr(IDX_OUTPUT_VALUE, 32'h5, RESP_OKAY);
    // Every code is loaded into both tables at once, so each half proves the other is ignored.
    for (int c = 0; c < 8; c++) begin
      for (int k = 0; k < 6; k++) wr(IDX_INPUT_SELECT_BIT2 + 10'(k), {28'h0, {4{c[2 - (k % 3)]}}}, RESP_OKAY);
      wr(IDX_PIN_DIRECTION, 32'h0, RESP_OKAY);
      // Two board patterns, so every enable and select level is seen both high and low.
      for (int q = 0; q < 2; q++) begin
        board_drive <= (q == 0) ? 4'hb : 4'h4;
        repeat (4) @(posedge aclk);
        check_word({12'h0, ctrl}, {12'h0, exp_ctrl(3'(c), board_drive)}, "input function");
      end
      check_word({24'h0, gpio_oe, gpio_out}, 32'h0, "input mode drive");
      rd(IDX_INPUT_VALUE, (c == 0) ? 32'h4 : 32'h0, RESP_OKAY);
      wr(IDX_PIN_DIRECTION, 32'hf, RESP_OKAY);
      for (int p = 0; p < 2; p++) begin
        status <= (p == 0) ? 6'h15 : 6'h2a;
        repeat (3) @(posedge aclk);
        check_word({28'h0, gpio_oe}, 32'hf, "output enable");
        check_word({28'h0, pin_level}, {28'h0, exp_out(3'(c), status, 4'h5)}, "output function");
        check_word({12'h0, ctrl}, 32'h0, "output mode control");
      end
      rd(IDX_INPUT_VALUE, 32'h0, RESP_OKAY);
      $display("test code %0d done", c);
    end
    tally_and_finish;
  end
endmodule // gpio_function_mux_tb_top
